// file: bench/acc_round_properties.sv
`timescale 1ns/1ps
`default_nettype none
// flag and bus behaviour seen only from the block's ports
module acc_round_properties #(
   parameter int WORD_W = 24
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // requests
   input wire acc_round_pkg::alu_req_t alu_req,
   input wire acc_round_pkg::reg_req_t reg_req,
   // outputs
   input wire logic [WORD_W-1:0] reg_rdata,
   input wire logic [WORD_W-1:0] bus_data,
   input wire logic bus_valid,
   input wire logic overflow_flag,
   input wire logic limit_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic rb;
   logic clr;
   logic ex;
   // decoded request kinds
   assign rb = alu_req.valid && alu_req.op == acc_round_pkg::OP_READ_BUS;
   assign clr = reg_req.wr && reg_req.addr == acc_round_pkg::OFS_STATUS;
   assign ex = alu_req.valid && alu_req.op inside {acc_round_pkg::OP_NO_SAT,
      acc_round_pkg::OP_WRITE_WORD, acc_round_pkg::OP_WRITE_LONG};
   sequence bus_read;
      rb ##1 bus_valid;
   endsequence
   a_bus_pulse: assert property (rb |-> bus_read)
      else $error("bus pulse missing");
   a_bus_quiet: assert property (!rb |=> !bus_valid && $stable(bus_data))
      else $error("bus moved without read");
   a_ovf_sticky: assert property (overflow_flag && !(clr && reg_req.wdata[0])
      |=> overflow_flag) else $error("overflow lost");
   a_lim_sticky: assert property (limit_flag && !(clr && reg_req.wdata[1])
      |=> limit_flag) else $error("limit lost");
   a_ovf_with_lim: assert property ($rose(overflow_flag) |-> limit_flag)
      else $error("overflow without limit");
   a_self_move_ovf: assert property (alu_req.valid && !overflow_flag &&
      alu_req.op == acc_round_pkg::OP_MOVE_SELF |=> !overflow_flag)
      else $error("self move set overflow");
   a_exempt_quiet: assert property (ex && !limit_flag |=> !limit_flag)
      else $error("exempt op saturated");
   a_flag_cause: assert property ($rose(limit_flag) |-> $past(alu_req.valid))
      else $error("limit rose without op");
endmodule : acc_round_properties
bind accumulator_round_saturate acc_round_properties #(.WORD_W(WORD_W)) props (
   .clk(clk), .srst(srst), .alu_req(alu_req), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .bus_data(bus_data), .bus_valid(bus_valid),
   .overflow_flag(overflow_flag), .limit_flag(limit_flag));
`default_nettype wire

// file: bench/accumulator_round_saturate_test.sv
`timescale 1ns/1ps
`default_nettype none
module accumulator_round_saturate_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   acc_round_pkg::alu_req_t alu_req;
   acc_round_pkg::reg_req_t reg_req = '0;
   logic [23:0] reg_rdata;
   logic [23:0] bus_data;
   logic bus_valid;
   logic overflow_flag;
   logic limit_flag;
   int error_cnt = 0;
   int num_checks = 0;
   // control, high, low, expected high, expected extension
   logic [23:0] rc [8][5] = '{
      '{24'h00_0000, 24'h10_0004, 24'h7f_ffff, 24'h10_0004, 24'h00_0000},
      '{24'h00_0000, 24'h10_0004, 24'h80_0001, 24'h10_0005, 24'h00_0000},
      '{24'h00_0000, 24'h10_0004, 24'h80_0000, 24'h10_0004, 24'h00_0000},
      '{24'h00_0000, 24'h10_0005, 24'h80_0000, 24'h10_0006, 24'h00_0000},
      '{24'h00_0004, 24'h10_0004, 24'h80_0000, 24'h10_0005, 24'h00_0000},
      '{24'h00_0004, 24'h10_0004, 24'h7f_ffff, 24'h10_0004, 24'h00_0000},
      '{24'h00_0005, 24'h10_0002, 24'h80_0000, 24'h10_0002, 24'h00_0000},
      '{24'h00_0000, 24'h7f_ffff, 24'h80_0001, 24'h80_0000, 24'h00_0000}};
   // clock
   always #5 clk = ~clk;
   core_request_model core (.clk(clk), .alu_req(alu_req));
   accumulator_round_saturate dut (.clk(clk), .srst(srst), .alu_req(alu_req),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .bus_data(bus_data),
      .bus_valid(bus_valid), .overflow_flag(overflow_flag), .limit_flag(limit_flag));
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [23:0] d);
      @(posedge clk);
      reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      reg_req <= '0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task rdc(input logic [3:0] a, input logic [23:0] exp);
      @(posedge clk);
      reg_req <= '{1'b0, 1'b1, a, 24'h00_0000};
      @(posedge clk);
      reg_req <= '0;
      #1 chk(reg_rdata, exp);
   endtask : rdc
   task acc0(input logic [23:0] e, input logic [23:0] h, input logic [23:0] l);
      rdc(acc_round_pkg::OFS_ACC_EXT, e);
      rdc(acc_round_pkg::OFS_ACC_HIGH, h);
      rdc(acc_round_pkg::OFS_ACC_LOW, l);
   endtask : acc0
   task complete_run;
      if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // watchdog, far beyond the roughly 200 cycles needed
   initial begin
      #100000;
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rdc(acc_round_pkg::OFS_CONTROL, 24'h00_0000);
      rdc(acc_round_pkg::OFS_STATUS, 24'h00_0000);
      wr(4'hf, 24'h12_3456);
      rdc(4'hf, 24'h00_0000);
      core.issue(acc_round_pkg::OP_WRITE_LONG, 1'b0, 24'h12_3456, 24'h65_4321);
      core.issue(acc_round_pkg::OP_NONE, 1'b0, 24'h00_0000, 24'h00_0000);
      acc0(24'h00_0000, 24'h12_3456, 24'h65_4321);
      core.issue(acc_round_pkg::OP_WRITE_WORD, 1'b0, 24'h80_0000, 24'h00_0000);
      acc0(24'hff_ffff, 24'h80_0000, 24'h00_0000);
      // each case loads, rounds, then checks the three parts
      for (int i = 0; i < 8; i++) begin
         wr(acc_round_pkg::OFS_CONTROL, rc[i][0]);
         core.issue(acc_round_pkg::OP_WRITE_LONG, 1'b0, rc[i][1], rc[i][2]);
         core.issue(acc_round_pkg::OP_ROUND, 1'b0, 24'h00_0000, 24'h00_0000);
         acc0(rc[i][4], rc[i][3], 24'h00_0000);
      end
      wr(acc_round_pkg::OFS_CONTROL, 24'h00_0000);
      core.issue(acc_round_pkg::OP_MULTIPLY, 1'b1, 24'h00_0001, 24'h00_0001);
      rdc(acc_round_pkg::OFS_RESULT_LOW, 24'h00_0002);
      core.issue(acc_round_pkg::OP_ADD, 1'b1, 24'h00_0000, 24'h00_0003);
      rdc(acc_round_pkg::OFS_RESULT_LOW, 24'h00_0005);
      core.issue(acc_round_pkg::OP_MAC_ROUND, 1'b1, 24'h40_0000, 24'h40_0000);
      rdc(acc_round_pkg::OFS_RESULT_HIGH, 24'h20_0000);
      rdc(acc_round_pkg::OFS_RESULT_LOW, 24'h00_0000);
      core.issue(acc_round_pkg::OP_MULT_ROUND, 1'b1, 24'h40_0000, 24'h40_0001);
      rdc(acc_round_pkg::OFS_RESULT_HIGH, 24'h20_0000);
      rdc(acc_round_pkg::OFS_RESULT_LOW, 24'h00_0000);
      core.issue(acc_round_pkg::OP_MULTIPLY, 1'b0, 24'h80_0000, 24'h80_0000);
      acc0(24'h00_0000, 24'h80_0000, 24'h00_0000);
      wr(acc_round_pkg::OFS_CONTROL, 24'h00_0008);
      core.issue(acc_round_pkg::OP_NO_SAT, 1'b0, 24'h00_0000, 24'h00_0000);
      rdc(acc_round_pkg::OFS_STATUS, 24'h00_0000);
      core.issue(acc_round_pkg::OP_READ_BUS, 1'b0, 24'h00_0000, 24'h00_0000);
      #1 chk({23'h0, bus_valid}, 24'h00_0001);
      chk(bus_data, 24'h7f_ffff);
      rdc(acc_round_pkg::OFS_STATUS, 24'h00_0002);
      wr(acc_round_pkg::OFS_STATUS, 24'h00_0003);
      rdc(acc_round_pkg::OFS_STATUS, 24'h00_0000);
      core.issue(acc_round_pkg::OP_MOVE_SELF, 1'b0, 24'h00_0000, 24'h00_0000);
      rdc(acc_round_pkg::OFS_STATUS, 24'h00_0002);
      acc0(24'h00_0000, 24'h7f_ffff, 24'hff_ffff);
      wr(acc_round_pkg::OFS_STATUS, 24'h00_0003);
      core.issue(acc_round_pkg::OP_WRITE_LONG, 1'b0, 24'h7f_ffff, 24'h80_0001);
      core.issue(acc_round_pkg::OP_ROUND, 1'b0, 24'h00_0000, 24'h00_0000);
      acc0(24'h00_0000, 24'h7f_ffff, 24'hff_ffff);
      core.issue(acc_round_pkg::OP_WRITE_WORD, 1'b0, 24'h00_0001, 24'h00_0000);
      rdc(acc_round_pkg::OFS_STATUS, 24'h00_0003);
      complete_run();
   end
endmodule : accumulator_round_saturate_test
`default_nettype wire

// file: bench/core_request_model.sv
`timescale 1ns/1ps
`default_nettype none
// instruction control side of the datapath
module core_request_model (
   // clock
   input wire logic clk,
   // request toward the datapath
   output var acc_round_pkg::alu_req_t alu_req
);
   initial alu_req = '0;
   // held for one edge only, so an op is never taken twice
   task issue(input acc_round_pkg::op_t op, input logic sel,
      input logic [23:0] hi, input logic [23:0] lo);
      @(posedge clk);
      alu_req <= '{1'b1, op, sel, hi, lo};
      @(posedge clk);
      alu_req <= '0;
   endtask : issue
endmodule : core_request_model
`default_nettype wire

// file: core/accumulator_round_saturate.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - operands are signed fractions with word extremes
// - accumulators span roughly minus to plus 256
// - word write: high part, sign extend, clear low
// - long write: low word low, high word high
// - products left aligned with zero lsb
// - round only when instruction requests it
// - scaling bits place the rounding boundary
// - round type select; convergent after reset
// - convergent: ties round to even kept lsb
// - twos complement: half or more rounds up
// - scaling moves rounding point, not contents
// - rounding ops leave low part cleared, except when clamped to the positive extreme
// - saturation mode clamps results to 48 bits
// - detect using ext bit7, ext bit0, high bit23
// - clamp patterns to positive or negative extremes
// - arithmetic saturation sets overflow flag
// - every saturation sets the limit flag
// - saturation suppressed for listed exempt operations
// - self move saturation sets only limit flag
// - accumulator is ext, high and low parts
// - limited bus read sets sticky limit flag
module accumulator_round_saturate #(
   parameter int WORD_W = acc_round_pkg::WORD_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // instruction request
   input wire acc_round_pkg::alu_req_t alu_req,
   // register port
   input wire acc_round_pkg::reg_req_t reg_req,
   output logic [WORD_W-1:0] reg_rdata,
   // result bus and flags
   output logic [WORD_W-1:0] bus_data,
   output logic bus_valid,
   output logic overflow_flag,
   output logic limit_flag
);

   localparam int ACC_W = acc_round_pkg::ACC_W;

   // whole state of the block
   typedef struct packed {
      logic [1:0][ACC_W-1:0] acc;
      logic [3:0] control;
      logic overflow;
      logic limit;
      logic [WORD_W-1:0] rdata;
      logic [WORD_W-1:0] bus;
      logic bus_valid;
   } state_t;

   state_t st;
   state_t next_st;

   logic [ACC_W-1:0] src;
   logic [ACC_W-1:0] operand;
   logic [ACC_W-1:0] sum;
   logic [ACC_W-1:0] rounded;
   logic [ACC_W-1:0] round_bit;
   logic [ACC_W-1:0] low_mask;
   logic [ACC_W-1:0] clamped;
   logic [47:0] product;
   logic [1:0] scale;
   logic round_req;
   logic sat_allowed;
   logic arith;
   logic is_self_move;
   logic half;
   logic above_half;
   logic kept_lsb;
   logic do_inc;
   logic sat_hit;
   logic [2:0] sat_bits;
   logic [ACC_W-1:0] bus_src;
   logic bus_over;
   // aligned product and the part dropped by a round
   logic [ACC_W-1:0] aligned_product;
   logic [ACC_W-1:0] discard_mask;
   // saturation arms
   logic sat_active;
   logic sat_to_pos;
   logic sat_to_neg;
   // flag events
   logic read_limited;
   logic status_wr;
   logic clear_overflow;
   logic clear_limit;
   logic set_overflow;
   logic set_limit;
   // bus and read words
   logic [WORD_W-1:0] bus_word;
   logic [WORD_W-1:0] read_word;
   logic [1:0][WORD_W-1:0] ext_view;
   logic [1:0][WORD_W-1:0] high_view;
   logic [1:0][WORD_W-1:0] low_view;

   assign scale = {st.control[acc_round_pkg::BIT_SCALE_HIGH],
                   st.control[acc_round_pkg::BIT_SCALE_LOW]};
   assign src = st.acc[alu_req.sel];

   // signed fractional product; bit 47 carries the true sign
   assign product = $signed(alu_req.word_hi) * $signed(alu_req.word_lo);
   // left aligned with a zero lsb, sign copied through ext
   assign aligned_product = {{8{product[47]}}, product[46:0], 1'b0};
   always_comb begin
      operand = '0;
      is_self_move = 1'b0;
      arith = 1'b1;
      sat_allowed = 1'b1;
      round_req = 1'b0;
      case (alu_req.op)
         acc_round_pkg::OP_WRITE_WORD: begin
            // sign through ext, low cleared
            operand = {{8{alu_req.word_hi[WORD_W-1]}}, alu_req.word_hi,
                       24'h00_0000};
            arith = 1'b0;
            sat_allowed = 1'b0;
         end
         acc_round_pkg::OP_WRITE_LONG: begin
            operand = {{8{alu_req.word_hi[WORD_W-1]}}, alu_req.word_hi,
                       alu_req.word_lo};
            arith = 1'b0;
            sat_allowed = 1'b0;
         end
         acc_round_pkg::OP_MULTIPLY: begin
            // product lands left aligned, lsb zero
            operand = aligned_product;
         end
         acc_round_pkg::OP_MULT_ROUND: begin
            operand = aligned_product;
            round_req = 1'b1;
         end
         acc_round_pkg::OP_MAC: begin
            operand = src + aligned_product;
         end
         acc_round_pkg::OP_MAC_ROUND: begin
            operand = src + aligned_product;
            round_req = 1'b1;
         end
         acc_round_pkg::OP_ROUND: begin
            operand = src;
            round_req = 1'b1;
         end
         acc_round_pkg::OP_ADD: begin
            operand = src + {{8{alu_req.word_hi[WORD_W-1]}}, alu_req.word_hi,
                             alu_req.word_lo};
         end
         acc_round_pkg::OP_MOVE_SELF: begin
            operand = src;
            is_self_move = 1'b1;
         end
         acc_round_pkg::OP_NO_SAT: begin
            // transfers, unsigned multiplies, compares, bit field ops
            operand = src;
            sat_allowed = 1'b0;
         end
         default: begin
            operand = src;
            arith = 1'b0;
            sat_allowed = 1'b0;
         end
      endcase
   end

   // rounding point follows scaling; contents are not shifted
   always_comb begin
      case (scale)
         2'b01: begin // scale down
            round_bit = 56'h00_0000_0100_0000 << 1;
         end
         2'b10: begin // scale up
            round_bit = 56'h00_0000_0100_0000 >> 1;
         end
         default: begin
            round_bit = 56'h00_0000_0100_0000;
         end
      endcase
   end
   assign low_mask = round_bit - 56'h00_0000_0000_0001;
   assign half = ((operand & low_mask) == (round_bit >> 1));
   assign above_half = ((operand & low_mask) > (round_bit >> 1));
   assign kept_lsb = |(operand & round_bit);

   // tie handling depends on rounding type
   always_comb begin
      case (st.control[acc_round_pkg::BIT_ROUND_TYPE])
         1'b1: begin
            // a tie always goes up, a small positive bias
            do_inc = above_half | half;
         end
         default: begin
            // a tie goes to the even kept value, no bias
            do_inc = above_half | (half & kept_lsb);
         end
      endcase
   end

   // carry runs into ext before saturation; discarded bits cleared
   assign sum = operand + (do_inc ? round_bit : 56'h00_0000_0000_0000);
   // low part is always cleared, whatever the rounding point
   assign discard_mask = low_mask | 56'h00_0000_00ff_ffff;
   assign rounded = round_req ? (sum & ~discard_mask) : operand;

   // saturation pattern check on the rounded value
   assign sat_bits = {rounded[55], rounded[48], rounded[47]};
   // plain writes and exempt ops bypass the limiter
   assign sat_active = st.control[acc_round_pkg::BIT_SAT_ENABLE] && sat_allowed && arith &&
                       alu_req.valid;
   // one arm per pattern, so the table can be checked line by line
   always_comb begin
      sat_to_pos = 1'b0;
      sat_to_neg = 1'b0;
      case (sat_bits)
         3'b001: begin
            sat_to_pos = 1'b1;
         end
         3'b010: begin
            sat_to_pos = 1'b1;
         end
         3'b011: begin
            sat_to_pos = 1'b1;
         end
         3'b100: begin
            sat_to_neg = 1'b1;
         end
         3'b101: begin
            sat_to_neg = 1'b1;
         end
         3'b110: begin
            sat_to_neg = 1'b1;
         end
         default: begin
            // 000 and 111 fit in 48 bits
            sat_to_pos = 1'b0;
         end
      endcase
   end

   // substitute the extreme of the same sign
   always_comb begin
      clamped = rounded;
      sat_hit = 1'b0;
      if (sat_active && sat_to_pos) begin
         clamped = acc_round_pkg::SAT_POS;
         sat_hit = 1'b1;
      end else if (sat_active && sat_to_neg) begin
         clamped = acc_round_pkg::SAT_NEG;
         sat_hit = 1'b1;
      end
   end

   // bus read of the high word, limited when ext is in use
   assign bus_src = st.acc[alu_req.sel];
   assign bus_over = (bus_src[55:47] != {9{bus_src[55]}});

   // transfer limiter; the accumulator itself keeps its value
   always_comb begin
      if (!bus_over) begin
         bus_word = bus_src[47:24];
      end else if (bus_src[55]) begin
         bus_word = acc_round_pkg::WORD_MIN;
      end else begin
         bus_word = acc_round_pkg::WORD_MAX;
      end
   end

   // flag events; a set beats a clear in the same cycle
   assign read_limited = alu_req.valid && (alu_req.op == acc_round_pkg::OP_READ_BUS) &&
                         bus_over;
   assign status_wr = reg_req.wr && (reg_req.addr == acc_round_pkg::OFS_STATUS);
   assign clear_overflow = status_wr && reg_req.wdata[acc_round_pkg::BIT_OVERFLOW];
   assign clear_limit = status_wr && reg_req.wdata[acc_round_pkg::BIT_LIMIT];
   assign set_limit = sat_hit || read_limited;
   assign set_overflow = sat_hit && !is_self_move;

   // per accumulator read views; ext reads sign extended
   for (genvar i = 0; i < 2; i++) begin : g_view
      assign ext_view[i] = {{16{st.acc[i][55]}}, st.acc[i][55:48]};
      assign high_view[i] = st.acc[i][47:24];
      assign low_view[i] = st.acc[i][23:0];
   end

   // software read mux; unmapped offsets read zero
   always_comb begin
      if (reg_req.addr == acc_round_pkg::OFS_CONTROL) begin
         read_word = {20'h0_0000, st.control};
      end else if (reg_req.addr == acc_round_pkg::OFS_STATUS) begin
         read_word = {22'h00_0000, st.limit, st.overflow};
      end else if (reg_req.addr == acc_round_pkg::OFS_ACC_EXT) begin
         read_word = ext_view[0];
      end else if (reg_req.addr == acc_round_pkg::OFS_ACC_HIGH) begin
         read_word = high_view[0];
      end else if (reg_req.addr == acc_round_pkg::OFS_ACC_LOW) begin
         read_word = low_view[0];
      end else if (reg_req.addr == acc_round_pkg::OFS_RESULT_HIGH) begin
         read_word = high_view[1];
      end else if (reg_req.addr == acc_round_pkg::OFS_RESULT_LOW) begin
         read_word = low_view[1];
      end else begin
         read_word = '0;
      end
   end

   // next state
   always_comb begin
      next_st = st;
      next_st.bus_valid = 1'b0;
      next_st.rdata = '0;
      if (alu_req.valid) begin
         if (alu_req.op == acc_round_pkg::OP_READ_BUS) begin
            // limited word onto the bus, accumulator untouched
            next_st.bus_valid = 1'b1;
            next_st.bus = bus_word;
         end else if (alu_req.op != acc_round_pkg::OP_NONE) begin
            next_st.acc[alu_req.sel] = clamped;
         end
      end
      // control register write
      if (reg_req.wr && (reg_req.addr == acc_round_pkg::OFS_CONTROL)) begin
         next_st.control = reg_req.wdata[3:0];
      end
      // clear-by-one, a same-cycle set wins
      if (set_overflow) begin
         next_st.overflow = 1'b1;
      end else if (clear_overflow) begin
         next_st.overflow = 1'b0;
      end
      if (set_limit) begin
         next_st.limit = 1'b1;
      end else if (clear_limit) begin
         next_st.limit = 1'b0;
      end
      // reads, data one cycle later
      if (reg_req.rd) begin
         next_st.rdata = read_word;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st.acc <= {acc_round_pkg::ACC_RESET, acc_round_pkg::ACC_RESET};
         st.control <= acc_round_pkg::CONTROL_RESET;
         st.overflow <= 1'b0;
         st.limit <= 1'b0;
         st.rdata <= '0;
         st.bus <= '0;
         st.bus_valid <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign bus_data = st.bus;
   assign bus_valid = st.bus_valid;
   assign overflow_flag = st.overflow;
   assign limit_flag = st.limit;

endmodule : accumulator_round_saturate

`default_nettype wire

// file: include/acc_round_pkg.sv
package acc_round_pkg;

   // accumulator geometry
   localparam int WORD_W = 24;
   localparam int EXT_W = 8;
   localparam int ACC_W = 56;
   localparam int LONG_W = 48;

   // register offsets
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_ACC_EXT = 4'h2;
   localparam logic [3:0] OFS_ACC_HIGH = 4'h3;
   localparam logic [3:0] OFS_ACC_LOW = 4'h4;
   localparam logic [3:0] OFS_RESULT_HIGH = 4'h5;
   localparam logic [3:0] OFS_RESULT_LOW = 4'h6;

   // control field positions
   localparam int BIT_SCALE_LOW = 0;
   localparam int BIT_SCALE_HIGH = 1;
   localparam int BIT_ROUND_TYPE = 2;
   localparam int BIT_SAT_ENABLE = 3;
   // status field positions
   localparam int BIT_OVERFLOW = 0;
   localparam int BIT_LIMIT = 1;

   // reset values
   localparam logic [3:0] CONTROL_RESET = 4'h0;
   localparam logic [ACC_W-1:0] ACC_RESET = 56'h00_0000_0000_0000;

   // word and accumulator extremes
   localparam logic [WORD_W-1:0] WORD_MAX = 24'h7f_ffff;
   localparam logic [WORD_W-1:0] WORD_MIN = 24'h80_0000;
   localparam logic [ACC_W-1:0] SAT_POS = 56'h00_7fff_ffff_ffff;
   localparam logic [ACC_W-1:0] SAT_NEG = 56'hff_8000_0000_0000;

   // operation codes from the instruction control
   typedef enum logic [3:0] {
      OP_NONE = 4'b0000,
      OP_WRITE_WORD = 4'b0001,
      OP_WRITE_LONG = 4'b0010,
      OP_MULTIPLY = 4'b0011,
      OP_MAC = 4'b0100,
      OP_ROUND = 4'b0101,
      OP_MULT_ROUND = 4'b0110,
      OP_MAC_ROUND = 4'b0111,
      OP_ADD = 4'b1000,
      OP_MOVE_SELF = 4'b1001,
      OP_NO_SAT = 4'b1010,
      OP_READ_BUS = 4'b1011
   } op_t;

   // one instruction request
   typedef struct packed {
      logic valid;
      op_t op;
      logic sel;
      logic [WORD_W-1:0] word_hi;
      logic [WORD_W-1:0] word_lo;
   } alu_req_t;

   // software port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [WORD_W-1:0] wdata;
   } reg_req_t;

endpackage : acc_round_pkg
